// file: dbh_config_tail.v
// Configuration header tail of one downstream bridge port: registers, reset and routing
`timescale 1ns/1ps
`default_nettype none
`include "dbh_consts.vh"

module dbh_config_tail #(
	// Device number of this port on the switch internal bus, for swizzle
	parameter [4:0] PORT_DEVICE_NUM = 5'h00
) (
	// Clock and reset
	input  wire        clk,
	input  wire        nrst,
	// Configuration request port, byte address of a dword
	input  wire        cfgRead,
	input  wire        cfgWrite,
	input  wire [7:0]  cfgAddr,
	input  wire [3:0]  cfgByteEn,
	input  wire [31:0] cfgWrData,
	output reg  [31:0] cfgRdData,
	output reg         cfgRdValid,
	// Fields held elsewhere in the header
	input  wire [3:0]  ioBottomLow,
	input  wire [3:0]  ioTopLow,
	input  wire        ioEnable,
	input  wire        memEnable,
	input  wire [5:0]  bridgeCtlLow,
	// Request to be classified for forwarding
	input  wire        reqValid,
	input  wire        reqIsIo,
	input  wire        reqIsMem,
	input  wire [31:0] reqAddr,
	output wire        fwdValid,
	output wire        fwdDownstream,
	// Downstream link reset control
	output reg         secondaryResetHold,
	output reg         hotResetStart,
	// Legacy interrupt routing
	input  wire        portIntxAssert,
	output reg  [3:0]  upstreamIntx
);

	// ****************************************************************
	// Storage
	// ****************************************************************
	reg  [15:0] ioWindowBottomHigh;
	reg  [15:0] ioWindowTopHigh;
	reg  [7:0]  interruptLineScratch;
	reg         secondarySideReset;
	reg         resetBitLast;

	wire [31:0] ioBottom;
	wire [31:0] ioTop;
	wire [15:0] bridgeControlView;
	wire        wrIoDword;
	wire        wrIntDword;
	wire [3:0]  intxRouted;

	// ****************************************************************
	// Dword map
	// ****************************************************************
	// Offsets kept at eight bits so the dword index is a clean slice
	localparam [7:0] OFS_IO  = `DBH_OFS_IO_HIGH;
	localparam [7:0] OFS_CAP = `DBH_OFS_CAP_PTR;
	localparam [7:0] OFS_INT = `DBH_OFS_INT_LINE;
	localparam [5:0] DW_IO   = OFS_IO[7:2];
	localparam [5:0] DW_CAP  = OFS_CAP[7:2];
	localparam [5:0] DW_INT  = OFS_INT[7:2];

	// Dword match shared by the write strobes; byte bits are ignored
	function hitsDword;
		input [7:0] addr;
		input [5:0] dword;
		begin
			hitsDword = (addr[7:2] == dword);
		end
	endfunction

	// ****************************************************************
	// Dword decode
	// ****************************************************************
	// Byte lanes select the 16-bit or 8-bit field inside each dword
	assign wrIoDword  = cfgWrite && hitsDword(cfgAddr, DW_IO);
	assign wrIntDword = cfgWrite && hitsDword(cfgAddr, DW_INT);

	// ****************************************************************
	// I/O window upper halves
	// ****************************************************************
	// Partial writes allowed: each byte lane stands alone
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ioWindowBottomHigh <= `DBH_RST_IO_HIGH;
			ioWindowTopHigh    <= `DBH_RST_IO_HIGH;
		end else if (wrIoDword) begin
			if (cfgByteEn[0]) begin
				ioWindowBottomHigh[7:0] <= cfgWrData[7:0];
			end
			if (cfgByteEn[1]) begin
				ioWindowBottomHigh[15:8] <= cfgWrData[15:8];
			end
			if (cfgByteEn[2]) begin
				ioWindowTopHigh[7:0] <= cfgWrData[23:16];
			end
			if (cfgByteEn[3]) begin
				ioWindowTopHigh[15:8] <= cfgWrData[31:24];
			end
		end
	end

	// ****************************************************************
	// Interrupt line and bridge control
	// ****************************************************************
	// Line byte is only stored and read back, nothing else taps it
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			interruptLineScratch <= `DBH_RST_INT_LINE;
			secondarySideReset   <= 1'b0;
		end else if (wrIntDword) begin
			if (cfgByteEn[0]) begin
				interruptLineScratch <= cfgWrData[7:0];
			end
			// Only bit 6 of the upper bridge control byte lanes lives here
			if (cfgByteEn[2]) begin
				secondarySideReset <= cfgWrData[16 + `DBH_BC_SEC_RESET_BIT];
			end
		end
	end

	// Bits 15:7 never stored, so writes to them vanish
	assign bridgeControlView = {4'h0,
	                            4'h0,
	                            1'b0,
	                            secondarySideReset,
	                            bridgeCtlLow};

	// ****************************************************************
	// Read path
	// ****************************************************************
	// Data registered one cycle after the read strobe; holes read zero
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfgRdData  <= 32'h00000000;
			cfgRdValid <= 1'b0;
		end else begin
			cfgRdValid <= cfgRead;
			if (cfgRead) begin
				case (cfgAddr[7:2])
					DW_IO: begin
						cfgRdData <= {ioWindowTopHigh, ioWindowBottomHigh};
					end
					DW_CAP: begin
						cfgRdData <= {24'h000000, `DBH_CAP_PTR_VALUE};
					end
					DW_INT: begin
						cfgRdData <= {bridgeControlView, `DBH_INT_PIN_VALUE,
						              interruptLineScratch};
					end
					default: begin
						cfgRdData <= 32'h00000000;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Secondary reset
	// ****************************************************************
	// Hold follows the bit; the start pulse tells the link to send
	// training sequences carrying the reset indication
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			secondaryResetHold <= 1'b0;
			hotResetStart      <= 1'b0;
			resetBitLast       <= 1'b0;
		end else begin
			resetBitLast       <= secondarySideReset;
			secondaryResetHold <= secondarySideReset;
			hotResetStart      <= secondarySideReset && !resetBitLast;
		end
	end

	// ****************************************************************
	// Forwarding decision
	// ****************************************************************
	// Low halves give address bits 15:12; bits below are 000h or FFFh
	assign ioBottom = {ioWindowBottomHigh, ioBottomLow, `DBH_IO_LOW_FILL_BOTTOM};
	assign ioTop    = {ioWindowTopHigh, ioTopLow, `DBH_IO_LOW_FILL_TOP};

	// VGA enable is bit 3 and VGA 16-bit decode bit 4 of the lower byte
	dbh_fwd_decode uDecode (
		.clk           (clk),
		.nrst          (nrst),
		.ioBottom      (ioBottom),
		.ioTop         (ioTop),
		.ioEnable      (ioEnable),
		.memEnable     (memEnable),
		.vgaEnable     (bridgeCtlLow[3]),
		.vgaFullDecode (bridgeCtlLow[4]),
		.reqValid      (reqValid),
		.reqIsIo       (reqIsIo),
		.reqIsMem      (reqIsMem),
		.reqAddr       (reqAddr),
		.fwdValid      (fwdValid),
		.fwdDownstream (fwdDownstream)
	);

	// ****************************************************************
	// Legacy interrupt routing
	// ****************************************************************
	// Port raises INTA on its primary side; the upstream bridge sees
	// it on pin (INTA + device number) mod 4
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gSwizzle
			assign intxRouted[g] = portIntxAssert &&
				({30'h0, PORT_DEVICE_NUM[1:0]} == g);
		end
	endgenerate

	// Registered so upward messages see a clean level
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			upstreamIntx <= 4'h0;
		end else begin
			upstreamIntx <= intxRouted;
		end
	end

endmodule
`default_nettype wire

// file: dbh_consts.vh
// Constants for the downstream bridge configuration header tail (offsets 30h to 3Fh)
`ifndef DBH_CONSTS_VH
`define DBH_CONSTS_VH

// ****************************************************************
// Register offsets (byte addresses of configuration space)
// ****************************************************************
`define DBH_OFS_IO_HIGH        8'h30
`define DBH_OFS_IO_TOP_HIGH    8'h32
`define DBH_OFS_CAP_PTR        8'h34
`define DBH_OFS_INT_LINE       8'h3C
`define DBH_OFS_INT_PIN        8'h3D
`define DBH_OFS_BRIDGE_CTL     8'h3E

// ****************************************************************
// Reset and constant values
// ****************************************************************
`define DBH_RST_IO_HIGH        16'h0000
`define DBH_RST_INT_LINE       8'hFF
`define DBH_CAP_PTR_VALUE      8'h50
`define DBH_INT_PIN_VALUE      8'h01
`define DBH_RST_BRIDGE_CTL     16'h0000

// ****************************************************************
// Bridge control field positions
// ****************************************************************
`define DBH_BC_SEC_RESET_BIT   6
`define DBH_BC_LOW_MSB         5

// ****************************************************************
// Forwarding decode constants
// ****************************************************************
`define DBH_IO_LOW_FILL_BOTTOM 12'h000
`define DBH_IO_LOW_FILL_TOP    12'hFFF
`define DBH_VGA_MEM_LO         32'h000A0000
`define DBH_VGA_MEM_HI         32'h000BFFFF
`define DBH_VGA_IO_A_LO        10'h3B0
`define DBH_VGA_IO_A_HI        10'h3BB
`define DBH_VGA_IO_B_LO        10'h3C0
`define DBH_VGA_IO_B_HI        10'h3DF

`endif

// file: dbh_fwd_decode.v
// Downstream forwarding decision for I/O window and VGA ranges
`timescale 1ns/1ps
`default_nettype none
`include "dbh_consts.vh"

module dbh_fwd_decode (
	// Clock and reset
	input  wire        clk,
	input  wire        nrst,
	// Window bounds
	input  wire [31:0] ioBottom,
	input  wire [31:0] ioTop,
	// Command and bridge control enables
	input  wire        ioEnable,
	input  wire        memEnable,
	input  wire        vgaEnable,
	input  wire        vgaFullDecode,
	// Request to classify
	input  wire        reqValid,
	input  wire        reqIsIo,
	input  wire        reqIsMem,
	input  wire [31:0] reqAddr,
	// Decision
	output reg         fwdValid,
	output reg         fwdDownstream
);

	// Inclusive range test, used for window and VGA ranges
	function inRange;
		input [31:0] addr;
		input [31:0] lo;
		input [31:0] hi;
		begin
			inRange = (addr >= lo) && (addr <= hi);
		end
	endfunction

	wire ioHit;
	wire vgaIoHit;
	wire vgaMemHit;
	wire next_fwd;

	// Window hit only for I/O requests with I/O space enabled
	assign ioHit = reqIsIo && ioEnable && inRange(reqAddr, ioBottom, ioTop);

	// VGA I/O: first 64 KB, aliases also hit unless full decode asked for
	assign vgaIoHit = reqIsIo && ioEnable && vgaEnable && (reqAddr[31:16] == 16'h0000)
		&& (!vgaFullDecode || (reqAddr[15:10] == 6'h00))
		&& (inRange({22'h0, reqAddr[9:0]}, {22'h0, `DBH_VGA_IO_A_LO}, {22'h0, `DBH_VGA_IO_A_HI})
		|| inRange({22'h0, reqAddr[9:0]}, {22'h0, `DBH_VGA_IO_B_LO}, {22'h0, `DBH_VGA_IO_B_HI}));

	// VGA frame buffer window
	assign vgaMemHit = reqIsMem && memEnable && vgaEnable
		&& inRange(reqAddr, `DBH_VGA_MEM_LO, `DBH_VGA_MEM_HI);

	assign next_fwd = ioHit || vgaIoHit || vgaMemHit;

	// Registered so the decision is one clean cycle after the request
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fwdValid      <= 1'b0;
			fwdDownstream <= 1'b0;
		end else begin
			fwdValid      <= reqValid;
			fwdDownstream <= reqValid && next_fwd;
		end
	end

endmodule
`default_nettype wire

// file: dbh_config_tail_props.sv
// Port checks for the configuration header tail
`timescale 1ns/1ps
`default_nettype none
module dbh_config_tail_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// Watched ports
	input wire logic        cfgRead,
	input wire logic [7:0]  cfgAddr,
	input wire logic [31:0] cfgRdData,
	input wire logic        cfgRdValid,
	input wire logic        reqValid,
	input wire logic        fwdValid,
	input wire logic        fwdDownstream,
	input wire logic        secondaryResetHold,
	input wire logic        hotResetStart,
	input wire logic        portIntxAssert,
	input wire logic [3:0]  upstreamIntx
);
	// ****************
	// Checks
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_read_answer_time: assert property (
		cfgRead |=> cfgRdValid) else $error("read not answered next cycle");
	a_read_answer_cause: assert property (
		cfgRdValid |-> $past(cfgRead)) else $error("read answer without read");
	a_cap_ptr_const: assert property (
		cfgRead && cfgAddr[7:2] == 6'h0D |=> cfgRdData == 32'h00000050)
		else $error("capability pointer dword wrong");
	a_bridge_high_zero: assert property (
		cfgRead && cfgAddr[7:2] == 6'h0F |=> cfgRdData[31:23] == 9'h000 && cfgRdData[15:8] == 8'h01)
		else $error("pin code or bridge fixed bits wrong");
	a_fwd_answer: assert property (
		reqValid |=> fwdValid) else $error("forward decision late");
	a_fwd_cause: assert property (
		fwdValid || fwdDownstream |-> fwdValid && $past(reqValid)) else $error("stray decision");
	a_hot_reset_edge: assert property (
		$rose(secondaryResetHold) |-> hotResetStart ##1 !hotResetStart)
		else $error("reset start pulse wrong");
	a_intx_route: assert property (
		$past(nrst) |-> upstreamIntx == {3'h0, $past(portIntxAssert)}) else $error("intx route wrong");
endmodule
bind dbh_config_tail dbh_config_tail_props dbh_config_tail_props_i (.clk(clk), .nrst(nrst),
	.cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
	.reqValid(reqValid), .fwdValid(fwdValid), .fwdDownstream(fwdDownstream),
	.secondaryResetHold(secondaryResetHold), .hotResetStart(hotResetStart),
	.portIntxAssert(portIntxAssert), .upstreamIntx(upstreamIntx));
`default_nettype wire

// file: dbh_host_model.sv
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module dbh_host_model (
	// Clock
	input  wire logic        clk,
	// Config request port
	output var logic         cfgRead,
	output var logic         cfgWrite,
	output var logic [7:0]   cfgAddr,
	output var logic [3:0]   cfgByteEn,
	output var logic [31:0]  cfgWrData,
	input  wire logic [31:0] cfgRdData,
	input  wire logic        cfgRdValid
);
	// Idle address and write data lines carry inverted leftovers, so stale values never look valid
	initial begin
		cfgRead = 1'b0;
		cfgWrite = 1'b0;
		cfgAddr = 8'hFF;
		cfgByteEn = 4'h0;
		cfgWrData = 32'h0;
	end
	// One-cycle write pulse
	task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(negedge clk);
		cfgWrite = 1'b1;
		cfgAddr = a;
		cfgByteEn = be;
		cfgWrData = d;
		@(negedge clk);
		cfgWrite = 1'b0;
		cfgAddr = ~a;
		cfgWrData = ~d;
	endtask
	// One-cycle read pulse, bounded wait for the answer
	task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d, output bit got);
		@(negedge clk);
		cfgRead = 1'b1;
		cfgAddr = a;
		@(negedge clk);
		cfgRead = 1'b0;
		cfgAddr = ~a;
		got = 0;
		for (int n = 0; n < 4 && !got; n++) begin
			got = cfgRdValid === 1'b1;
			d = cfgRdData;
			if (!got) @(negedge clk);
		end
	endtask
endmodule
`default_nettype wire

// file: dbh_config_tail_tb_top.sv
// Self-checking bench for the configuration header tail
`timescale 1ns/1ps
`default_nettype none
module dbh_config_tail_tb_top;
	logic clk, nrst, rdV, ioEn, memEn, rqV, rqIo, rqMem, fV, fD, srH, hot, intx, got;
	logic cRd, cWr;
	logic [7:0] cA, a, mLine;
	logic [3:0] cBe, bLo, tLo, upI;
	logic [31:0] cWd, rd, rqA, d, b, t;
	logic [5:0] bcLow;
	logic [15:0] mBot, mTop;
	logic mSr;
	int num_errors, cmp_count, seed;
	logic [7:0] adr [4] = '{8'h30, 8'h34, 8'h3C, 8'h38};
	dbh_host_model dbh_host_model_i (.clk(clk), .cfgRead(cRd), .cfgWrite(cWr), .cfgAddr(cA),
		.cfgByteEn(cBe), .cfgWrData(cWd), .cfgRdData(rd), .cfgRdValid(rdV));
	dbh_config_tail dbh_config_tail_i (.clk(clk), .nrst(nrst), .cfgRead(cRd), .cfgWrite(cWr),
		.cfgAddr(cA), .cfgByteEn(cBe), .cfgWrData(cWd), .cfgRdData(rd), .cfgRdValid(rdV),
		.ioBottomLow(bLo), .ioTopLow(tLo), .ioEnable(ioEn), .memEnable(memEn), .bridgeCtlLow(bcLow),
		.reqValid(rqV), .reqIsIo(rqIo), .reqIsMem(rqMem), .reqAddr(rqA), .fwdValid(fV),
		.fwdDownstream(fD), .secondaryResetHold(srH), .hotResetStart(hot),
		.portIntxAssert(intx), .upstreamIntx(upI));
	// 250 MHz core clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Write through the host and track the reference copy lane by lane
	task automatic wr(input logic [7:0] x, input logic [3:0] be, input logic [31:0] v);
		logic oldSr;
		oldSr = mSr;
		dbh_host_model_i.cfg_wr(x, be, v);
		if (x[7:2] == 6'h0C) begin
			if (be[0]) mBot[7:0] = v[7:0];
			if (be[1]) mBot[15:8] = v[15:8];
			if (be[2]) mTop[7:0] = v[23:16];
			if (be[3]) mTop[15:8] = v[31:24];
		end
		if (x[7:2] == 6'h0F && be[0]) mLine = v[7:0];
		if (x[7:2] == 6'h0F && be[2]) mSr = v[22];
		// Start pulse stands one edge after the stored bit rises
		@(negedge clk);
		chk("hotResetStart", 32'(hot), 32'(mSr && !oldSr));
	endtask
	function automatic logic [31:0] expRd(input logic [7:0] x);
		case (x[7:2])
			6'h0C: return {mTop, mBot};
			6'h0D: return 32'h00000050;
			6'h0F: return {9'h000, mSr, bcLow, 8'h01, mLine};
			default: return 32'h0;
		endcase
	endfunction
	task automatic rdchk(input logic [7:0] x);
		dbh_host_model_i.cfg_rd(x, d, got);
		if (!got) begin
			num_errors++;
			end_of_test();
		end
		chk("cfgRdData", d, expRd(x));
		chk("secondaryResetHold", 32'(srH), 32'(mSr));
		chk("upstreamIntx", 32'(upI), 32'(intx));
	endtask
	function automatic logic fwdExp(input logic io, input logic [31:0] x);
		logic vga;
		vga = x[31:16] == 16'h0 && (!bcLow[4] || x[15:10] == 6'h00) && ((x[9:0] >= 10'h3B0
			&& x[9:0] <= 10'h3BB) || (x[9:0] >= 10'h3C0 && x[9:0] <= 10'h3DF));
		if (io) return ioEn && ((x >= b && x <= t) || (bcLow[3] && vga));
		return memEn && bcLow[3] && x >= 32'h000A0000 && x <= 32'h000BFFFF;
	endfunction
	// Main sequence
	initial begin
		{nrst, ioEn, memEn, rqV, rqIo, rqMem, intx, bLo, tLo, bcLow, rqA} = 0;
		{mBot, mTop, mSr, mLine} = {32'h0, 1'b0, 8'hFF};
		seed = $urandom(34);
		repeat (6) @(posedge clk);
		@(negedge clk) nrst = 1'b1;
		foreach (adr[i]) rdchk(adr[i]);
		// Directed secondary reset set and clear through the upper lane
		wr(8'h3E, 4'h4, 32'h00400000);
		rdchk(8'h3C);
		wr(8'h3E, 4'h4, 32'h00000000);
		rdchk(8'h3C);
		// Random writes, each read straight back
		for (int i = 0; i < 60; i++) begin
			a = adr[$urandom % 4] | 8'($urandom % 4);
			wr(a, 4'($urandom), $urandom);
			bcLow = 6'($urandom);
			intx = 1'($urandom);
			rdchk(a);
		end
		// Window edges, VGA ranges and enables
		for (int i = 0; i < 80; i++) begin
			wr(8'h30, 4'hF, $urandom);
			{bLo, tLo, ioEn, memEn, bcLow} = 16'($urandom);
			b = {mBot, bLo, 12'h000};
			t = {mTop, tLo, 12'hFFF};
			d = $urandom % 4 == 0 ? b - 1 : $urandom % 3 == 0 ? t + 1 : $urandom % 2 ? b : t;
			if (i % 3 == 1) d = {16'h0, 6'($urandom), 10'h3AF + 10'($urandom % 50)};
			rqIo = i % 3 != 2;
			rqMem = !rqIo;
			if (rqMem) d = 32'h0009FFFF + $urandom % 32'h00020002;
			@(negedge clk);
			rqV = 1'b1;
			rqA = d;
			@(negedge clk);
			rqV = 1'b0;
			rqA = ~d;
			chk("fwdValid", 32'(fV), 32'h1);
			chk("fwdDownstream", 32'(fD), 32'(fwdExp(rqIo, d)));
			// Decision lasts one cycle only
			@(negedge clk);
			chk("fwdValid", 32'(fV), 32'h0);
			chk("fwdDownstream", 32'(fD), 32'h0);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
